// ### logic/io_cmd_regs.svh
// Purpose: constants for the i/o register command responder
// Assumes: byte framing is done by the transport outside
// Notes:   codes are hexadecimal as carried on the byte stream
`ifndef IO_CMD_REGS_SVH
`define IO_CMD_REGS_SVH
`define OP_READ_COILS     8'h01
`define OP_READ_HOLDING   8'h03
`define OP_READ_INPUT     8'h04
`define OP_WRITE_COILS    8'h0f
`define OP_WRITE_HOLDING  8'h10
`define ERR_FLAG          8'h80
`define ERR_FUNCTION      8'h01
`define ERR_ADDRESS       8'h02
`define ERR_VALUE         8'h03
`define ERR_FAILURE       8'h04
`define HDR_LAST_READ     4'h4
`define HDR_LAST_WRITE    4'h5
`define ONE_COUNT         16'h0001
`endif

// ### logic/io_cmd_pkg.sv
// Purpose: types shared by the responder files
// Assumes: nothing
// Notes:   one-hot state codes written out
package io_cmd_pkg;
	typedef enum logic [5:0]
	{
		ST_HEADER = 6'b000001,
		ST_DATA   = 6'b000010,
		ST_EXEC   = 6'b000100,
		ST_REPLY  = 6'b001000,
		ST_DRAIN  = 6'b010000,
		ST_WAIT   = 6'b100000
	} state_t;
endpackage

// ### logic/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic pinIn,
	output var  logic level
);
	logic s1;
	logic s2;
	logic s3;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end
		else if (ce)
		begin
			s1 <= pinIn;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				level <= s3;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ### logic/io_register_command_responder.sv
// Purpose: byte command interpreter giving a host access to i/o channel registers
// Assumes: request bytes arrive framed by reqValid/reqLast; one request at a time
// Notes:   coils and 16-bit registers are local arrays; addresses outside them fail
//
// Contract
// [RQ1] response echoes command, top bit on error
// [RQ2] read reply: byte count, then register data
// [RQ3] write codes 0x0f coils, 0x10 holding
// [RQ4] host sends start and count, bytes 2-5
// [RQ5] byte 6 is write data length
// [RQ6] multi-byte values travel big-endian
// [RQ7] coil bit zero is starting register
// [RQ8] consecutive coils share one packed byte
// [RQ9] write reply: code, start, count written
// [RQ10] failed write: flagged code plus error code
// [RQ11] error 01 for unsupported command code
// [RQ12] error 02 for illegal register address
// [RQ13] error 03 for illegal data value
// [RQ14] error 04 on unrecoverable execution failure
// [RQ15] read codes 0x01, 0x03, 0x04
// [RQ16] read request carries start and count
// [RQ17] each word register returns two bytes
// [RQ18] byte count mismatch rejected, nothing written
`timescale 1ns/1ps
`default_nettype none
`include "io_cmd_regs.svh"
module io_register_command_responder
	import io_cmd_pkg::*;
#(
	parameter int COIL_BASE  = 16'h1800,
	parameter int COIL_NUM   = 64,
	parameter int HOLD_BASE  = 16'h1800,
	parameter int HOLD_NUM   = 32,
	parameter int INPUT_BASE = 16'h0800,
	parameter int INPUT_NUM  = 16,
	parameter int MAX_DATA   = 64
)
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [7:0]  reqData,
	input  wire logic        reqValid,
	input  wire logic        reqLast,
	input  wire logic        execFault,
	input  wire logic [INPUT_NUM-1:0] inputPins,
	output var  logic [7:0]  rspData,
	output var  logic        rspValid,
	output var  logic        rspLast,
	input  wire logic        rspReady,
	output var  logic [COIL_NUM-1:0] coilOut
);
	// ************************************************************
	// input register sampling
	// ************************************************************
	logic [INPUT_NUM-1:0] inLevel;
	genvar g;
	generate
		for (g = 0; g < INPUT_NUM; g++)
		begin : gSync
			pin_sync uSync
			(
				.clk    (clk),
				.resetn (resetn),
				.ce     (ce),
				.pinIn  (inputPins[g]),
				.level  (inLevel[g])
			);
		end
	endgenerate

	// ************************************************************
	// request capture
	// ************************************************************
	state_t      state;
	logic [7:0]  opcode;
	logic [15:0] start;
	logic [15:0] count;
	logic [7:0]  dataLen;
	logic [3:0]  hdrIdx;
	logic [7:0]  dataIdx;
	logic        tooLong;
	logic [7:0]  dataBuf [MAX_DATA];
	logic [15:0] holding [HOLD_NUM];
	logic [7:0]  errCode;
	logic [7:0]  rspLen;
	logic [7:0]  rspIdx;
	logic        isWrite;
	logic        isRead;
	logic        byteIn;

	assign byteIn  = reqValid && ce;
	assign isWrite = (opcode == `OP_WRITE_COILS) || (opcode == `OP_WRITE_HOLDING); // RQ3
	assign isRead  = (opcode == `OP_READ_COILS) || (opcode == `OP_READ_HOLDING)
		|| (opcode == `OP_READ_INPUT); // RQ15

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state   <= ST_HEADER;
			opcode  <= 8'h00;
			start   <= 16'h0000;
			count   <= 16'h0000;
			dataLen <= 8'h00;
			hdrIdx  <= 4'h0;
			dataIdx <= 8'h00;
			tooLong <= 1'b0;
		end
		else if (ce)
		begin
			case (state)
			ST_HEADER:
				if (reqValid)
				begin
					case (hdrIdx)
					4'h0: opcode <= reqData;
					4'h1: start[15:8] <= reqData; // RQ4 RQ16 RQ6
					4'h2: start[7:0] <= reqData;
					4'h3: count[15:8] <= reqData;
					4'h4: count[7:0] <= reqData;
					default: dataLen <= reqData; // RQ5
					endcase
					hdrIdx <= hdrIdx + 4'h1;
					dataIdx <= 8'h00;
					tooLong <= 1'b0;
					if (reqLast)
					begin
						hdrIdx <= 4'h0;
						state <= ST_EXEC;
					end
					else if (hdrIdx == `HDR_LAST_WRITE || (hdrIdx == `HDR_LAST_READ
						&& !isWrite))
						state <= (hdrIdx == `HDR_LAST_WRITE) ? ST_DATA : ST_DRAIN;
				end
			ST_DATA, ST_DRAIN:
				if (reqValid)
				begin
					if (state == ST_DATA)
					begin
						if (dataIdx < 8'(MAX_DATA))
							dataIdx <= dataIdx + 8'h01;
						else
							tooLong <= 1'b1;
					end
					if (reqLast)
					begin
						hdrIdx <= 4'h0;
						state <= ST_EXEC;
					end
				end
			ST_EXEC:
				state <= ST_REPLY;
			ST_REPLY:
				if (rspValid && rspReady && rspLast) // leave once the last byte is taken
					state <= ST_HEADER;
			default:
				state <= ST_HEADER;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce && byteIn && state == ST_DATA && dataIdx < 8'(MAX_DATA))
			dataBuf[dataIdx[5:0]] <= reqData;
	end

	// ************************************************************
	// validation
	// ************************************************************
	logic [16:0] lastAddr;
	logic [16:0] base;
	logic [16:0] limit;
	logic [15:0] needLen;
	logic [7:0]  next_err;

	assign lastAddr = 17'(start) + 17'(count) - 17'h1;

	always_comb
	begin
		base = 17'(HOLD_BASE);
		limit = 17'(HOLD_BASE + HOLD_NUM);
		if (opcode == `OP_READ_COILS || opcode == `OP_WRITE_COILS)
		begin
			base = 17'(COIL_BASE);
			limit = 17'(COIL_BASE + COIL_NUM);
		end
		else if (opcode == `OP_READ_INPUT)
		begin
			base = 17'(INPUT_BASE);
			limit = 17'(INPUT_BASE + INPUT_NUM);
		end
		// RQ8: coils pack eight to a byte, words take two bytes each
		if (opcode == `OP_READ_COILS || opcode == `OP_WRITE_COILS)
			needLen = 16'((17'(count) + 17'h7) >> 3); // RQ8
		else
			needLen = count[15] ? 16'hffff : {count[14:0], 1'b0}; // RQ17
		next_err = 8'h00;
		if (!isRead && !isWrite)
			next_err = `ERR_FUNCTION; // RQ11
		else if (count == 16'h0000 || needLen > 16'(MAX_DATA))
			next_err = `ERR_VALUE; // RQ13
		else if (17'(start) < base || lastAddr >= limit)
			next_err = `ERR_ADDRESS; // RQ12
		else if (isWrite && (16'(dataLen) != needLen || 16'(dataIdx) != needLen || tooLong))
			next_err = `ERR_VALUE; // RQ18
		else if (execFault)
			next_err = `ERR_FAILURE; // RQ14
	end

	// ************************************************************
	// register execution
	// ************************************************************
	logic [15:0] offs;
	assign offs = 16'(17'(start) - base);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			errCode <= 8'h00;
			rspLen  <= 8'h00;
			coilOut <= '0;
		end
		else if (ce && state == ST_EXEC)
		begin
			errCode <= next_err;
			if (next_err != 8'h00)
				rspLen <= 8'h01; // RQ10
			else if (isWrite)
				rspLen <= 8'h04; // RQ9
			else
				rspLen <= 8'(needLen); // RQ2
			if (next_err == 8'h00 && opcode == `OP_WRITE_COILS)
			begin
				for (int i = 0; i < COIL_NUM; i++)
					if (i >= offs && i < offs + count)
						coilOut[i] <= dataBuf[(i - offs) / 8][(i - offs) % 8]; // RQ7
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce && state == ST_EXEC && next_err == 8'h00 && opcode == `OP_WRITE_HOLDING)
		begin
			for (int i = 0; i < HOLD_NUM; i++)
				if (i >= offs && i < offs + count)
					holding[i] <= {dataBuf[2*(i-offs)], dataBuf[2*(i-offs)+1]}; // RQ6
		end
	end

	// ************************************************************
	// response streaming
	// ************************************************************
	logic [7:0] next_byte;
	logic [15:0] itemIdx;
	logic [15:0] word;
	logic [7:0]  lastIdx;

	assign lastIdx = (errCode != 8'h00 || isWrite) ? rspLen : rspLen + 8'h01; // reads add the count byte

	always_comb
	begin
		itemIdx = offs + 16'(rspIdx - 8'h2);
		word = 16'h0000;
		if (opcode == `OP_READ_INPUT)
			word = 16'(inLevel[itemIdx[3:0] % INPUT_NUM]);
		else if (itemIdx[15:1] < 15'(HOLD_NUM))
			word = holding[(offs + 16'((rspIdx - 8'h2) >> 1)) % HOLD_NUM];
		next_byte = 8'h00;
		if (rspIdx == 8'h00)
			next_byte = (errCode != 8'h00) ? (opcode | `ERR_FLAG) : opcode; // RQ1
		else if (errCode != 8'h00)
			next_byte = errCode; // RQ10
		else if (isWrite)
		begin
			case (rspIdx)
			8'h01: next_byte = start[15:8]; // RQ9
			8'h02: next_byte = start[7:0];
			8'h03: next_byte = count[15:8];
			default: next_byte = count[7:0];
			endcase
		end
		else if (rspIdx == 8'h01)
			next_byte = rspLen; // RQ2
		else if (opcode == `OP_READ_COILS)
		begin
			for (int b = 0; b < 8; b++)
				if (16'((rspIdx - 8'h2) * 8 + b) < count)
					next_byte[b] = coilOut[(offs + 16'((rspIdx - 8'h2) * 8 + b)) % COIL_NUM]; // RQ7 RQ8
		end
		else
		begin
			itemIdx = 16'((rspIdx - 8'h2) >> 1);
			if (opcode == `OP_READ_INPUT)
				word = 16'(inLevel[(offs + itemIdx) % INPUT_NUM]);
			next_byte = (rspIdx[0] == 1'b0) ? word[15:8] : word[7:0]; // RQ6 RQ17
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rspIdx   <= 8'h00;
			rspData  <= 8'h00;
			rspValid <= 1'b0;
			rspLast  <= 1'b0;
		end
		else if (ce)
		begin
			if (state == ST_EXEC)
				rspIdx <= 8'h00;
			else if (state == ST_REPLY && (!rspValid || rspReady))
			begin
				if (rspValid && rspLast)
				begin
					rspValid <= 1'b0;
					rspLast  <= 1'b0;
				end
				else
				begin
					rspData  <= next_byte;
					rspValid <= 1'b1;
					rspLast  <= (rspIdx == lastIdx); // RQ2 RQ9 RQ10
					rspIdx   <= rspIdx + 8'h01;
				end
			end
			else if (rspReady)
			begin
				rspValid <= 1'b0;
				rspLast  <= 1'b0;
			end
		end
	end
endmodule // io_register_command_responder
`default_nettype wire

// ### verif/io_cmd_sva.sv
// Purpose: port checker for the command responder
// Assumes: ce stays high while a request runs
// Notes:   idx counts accepted reply bytes
`timescale 1ns/1ps
`default_nettype none
module io_cmd_sva
(
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       ce,
	input wire logic [7:0] reqData,
	input wire logic       reqValid,
	input wire logic       reqLast,
	input wire logic [7:0] rspData,
	input wire logic       rspValid,
	input wire logic       rspLast,
	input wire logic       rspReady
);
	logic [7:0] code;
	logic [7:0] hi;
	logic [7:0] len;
	logic [7:0] idx;
	logic [7:0] ri;
	logic       bad;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ****
	// request and reply tracking
	// ****
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			ri <= 8'h00;
		else if (ce && reqValid)
			ri <= reqLast ? 8'h00 : ri + 8'h01;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			code <= 8'h00;
			hi <= 8'h00;
		end
		else if (ce && reqValid && ri == 8'h00)
			code <= reqData;
		else if (ce && reqValid && ri == 8'h01)
			hi <= reqData;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			idx <= 8'h00;
		else if (rspValid && rspReady)
			idx <= rspLast ? 8'h00 : idx + 8'h01;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			bad <= 1'b0;
			len <= 8'h00;
		end
		else if (rspValid && rspReady && idx == 8'h00)
			bad <= rspData[7];
		else if (rspValid && rspReady && idx == 8'h01)
			len <= rspData;
	// ****
	// properties
	// ****
	sequence s_flag;
		rspValid && rspReady && idx == 8'h00 && rspData[7];
	endsequence
	sequence s_tail;
		rspValid && rspLast && rspData inside {8'h01, 8'h02, 8'h03, 8'h04};
	endsequence
	property p_err; s_flag |=> s_tail; endproperty
	property p_hold; rspValid && !rspReady |=> rspValid && $stable(rspData); endproperty
	property p_echo; rspValid && idx == 8'h00 |-> rspData[6:0] == code[6:0]; endproperty
	property p_ans; ce && reqValid && reqLast |-> ##[3:4] rspValid && idx == 8'h00; endproperty
	property p_rlen; rspValid && rspLast && !bad && code < 8'h05 |-> idx == len + 8'h01; endproperty
	property p_wlen; rspValid && rspLast && !bad && code > 8'h0e |-> idx == 8'h04; endproperty
	property p_wsta; rspValid && idx == 8'h01 && !bad && code > 8'h0e |-> rspData == hi; endproperty
	property p_func;
		rspValid && idx == 8'h00 && !(code inside {8'h01, 8'h03, 8'h04, 8'h0f, 8'h10})
		|-> rspData == (code | 8'h80);
	endproperty
	a_err: assert property (p_err) else $error("error reply tail wrong");
	a_hold: assert property (p_hold) else $error("reply byte changed while stalled");
	a_echo: assert property (p_echo) else $error("reply code not echoed");
	a_ans: assert property (p_ans) else $error("reply did not start in time");
	a_rlen: assert property (p_rlen) else $error("read reply length wrong");
	a_wlen: assert property (p_wlen) else $error("write reply length wrong");
	a_wsta: assert property (p_wsta) else $error("write reply start wrong");
	a_func: assert property (p_func) else $error("bad code not flagged");
endmodule // io_cmd_sva
bind io_register_command_responder io_cmd_sva chk
(
	.clk(clk), .resetn(resetn), .ce(ce), .reqData(reqData), .reqValid(reqValid),
	.reqLast(reqLast), .rspData(rspData), .rspValid(rspValid), .rspLast(rspLast),
	.rspReady(rspReady)
);
`default_nettype wire

// ### verif/io_host_model.sv
// Purpose: host side that sends frames and takes replies
// Assumes: driven on the falling edge
// Notes:   reply stalls are random
`timescale 1ns/1ps
`default_nettype none
module io_host_model
(
	input  wire logic       clk,
	input  wire logic [7:0] rspData,
	input  wire logic       rspValid,
	input  wire logic       rspLast,
	output var  logic [7:0] reqData,
	output var  logic       reqValid,
	output var  logic       reqLast,
	output var  logic       rspReady
);
	initial
	begin
		reqData = 8'h00;
		reqValid = 1'b0;
		reqLast = 1'b0;
		rspReady = 1'b0;
	end
	// ****
	// one frame out, whole reply back
	// ****
	task automatic run(input logic [7:0] q[$], output logic [7:0] r[$]);
		int n;
		r = {};
		foreach (q[i])
		begin
			@(negedge clk);
			reqData = q[i];
			reqValid = 1'b1;
			reqLast = (i == q.size() - 1);
		end
		@(negedge clk);
		reqValid = 1'b0;
		reqLast = 1'b0;
		reqData = ~reqData; // no stale byte on a released line
		for (n = 0; n < 400; n++)
		begin
			@(negedge clk);
			rspReady = ($urandom % 3) != 0;
			if (rspValid && rspReady)
			begin
				r.push_back(rspData);
				if (rspLast)
					break;
			end
		end
		@(negedge clk);
		rspReady = 1'b0;
	endtask
endmodule // io_host_model
`default_nettype wire

// ### verif/test_io_register_command_responder.sv
// Purpose: self-checking bench for the command responder
// Assumes: default maps, ce held high
// Notes:   holding values tracked in a local copy
`timescale 1ns/1ps
`default_nettype none
module test_io_register_command_responder;
	logic        clk;
	logic        resetn;
	logic        ce;
	logic        execFault;
	logic [7:0]  reqData;
	logic [7:0]  rspData;
	logic        reqValid;
	logic        reqLast;
	logic        rspValid;
	logic        rspLast;
	logic        rspReady;
	logic [15:0] inputPins;
	logic [63:0] coilOut;
	logic [15:0] hold [32];
	logic [7:0]  q[$];
	logic [7:0]  e[$];
	logic [7:0]  r[$];
	logic [7:0]  rdExp[$];
	int          n_errors;
	int          num_checks;
	int          i;
	int          k;
	int          a;
	int          c;
	io_register_command_responder dut
	(
		.clk(clk), .resetn(resetn), .ce(ce), .reqData(reqData), .reqValid(reqValid),
		.reqLast(reqLast), .execFault(execFault), .inputPins(inputPins),
		.rspData(rspData), .rspValid(rspValid), .rspLast(rspLast),
		.rspReady(rspReady), .coilOut(coilOut)
	);
	io_host_model host
	(
		.clk(clk), .rspData(rspData), .rspValid(rspValid), .rspLast(rspLast),
		.reqData(reqData), .reqValid(reqValid), .reqLast(reqLast), .rspReady(rspReady)
	);
	// ****
	// helpers
	// ****
	function automatic logic [7:0] flag(input logic [7:0] cd);
		return cd | 8'h80;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xact();
		host.run(q, r);
		check(16'(r.size()), 16'(e.size()));
		foreach (e[j])
			check(16'(r[j]), 16'(e[j]));
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#(25 * 30000);
		n_errors++;
		give_verdict();
	end
	// ****
	// tests
	// ****
	initial
	begin
		k = $urandom(38443);
		resetn = 1'b0;
		ce = 1'b1;
		execFault = 1'b0;
		inputPins = 16'h0000;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		q = {8'h01, 8'h18, 8'h01, 8'h00, 8'h01};
		e = {8'h01, 8'h01, 8'h00};
		xact();
		q = {8'h0f, 8'h18, 8'h02, 8'h00, 8'h02, 8'h01, 8'h03};
		e = {8'h0f, 8'h18, 8'h02, 8'h00, 8'h02};
		xact();
		check(16'(coilOut[7:0]), 16'h000c);
		q = {8'h01, 8'h18, 8'h00, 8'h00, 8'h0a};
		e = {8'h01, 8'h02, 8'h0c, 8'h00};
		xact();
		$display("coil test done");
		for (k = 0; k < 6; k++)
		begin
			a = $urandom_range(0, 29);
			c = $urandom_range(1, 3);
			q = {8'h10, 8'h18, 8'(a), 8'h00, 8'(c), 8'(2 * c)};
			e = {8'h03, 8'(2 * c)};
			for (i = 0; i < c; i++)
			begin
				hold[a + i] = 16'($urandom);
				q.push_back(hold[a + i][15:8]);
				q.push_back(hold[a + i][7:0]);
				e.push_back(hold[a + i][15:8]);
				e.push_back(hold[a + i][7:0]);
			end
			rdExp = e;
			e = {8'h10, 8'h18, 8'(a), 8'h00, 8'(c)};
			xact();
			e = rdExp;
			q = {8'h03, 8'h18, 8'(a), 8'h00, 8'(c)};
			xact();
		end
		q = {8'h10, 8'h18, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
		e = {8'h10, 8'h18, 8'h00, 8'h00, 8'h01};
		xact();
		q = {8'h10, 8'h18, 8'h00, 8'h00, 8'h01, 8'h03, 8'haa, 8'hbb, 8'hcc};
		e = {flag(8'h10), 8'h03};
		xact();
		q = {8'h03, 8'h18, 8'h00, 8'h00, 8'h01};
		e = {8'h03, 8'h02, 8'h12, 8'h34};
		xact();
		q = {8'h05, 8'h18, 8'h00, 8'h00, 8'h01};
		e = {flag(8'h05), 8'h01};
		xact();
		q = {8'h03, 8'h19, 8'h00, 8'h00, 8'h01};
		e = {flag(8'h03), 8'h02};
		xact();
		q = {8'h04, 8'h08, 8'h00, 8'h00, 8'h00};
		e = {flag(8'h04), 8'h03};
		xact();
		execFault = 1'b1;
		q = {8'h01, 8'h18, 8'h00, 8'h00, 8'h01};
		e = {flag(8'h01), 8'h04};
		xact();
		execFault = 1'b0;
		$display("error test done");
		inputPins = 16'($urandom);
		repeat (6) @(negedge clk);
		q = {8'h04, 8'h08, 8'h00, 8'h00, 8'h02};
		e = {8'h04, 8'h04, 8'h00, 8'(inputPins[0]), 8'h00, 8'(inputPins[1])};
		xact();
		$display("input test done");
		give_verdict();
	end
endmodule // test_io_register_command_responder
`default_nettype wire
